// ==== hdl/peripheral_irq_flag_bank.sv ====
// Contract
// - a flag is set by its event whatever the mask or enables say.
// - six eight-bit flag registers, bytes of one 48-bit bank, hold all request flags.
// - flag one bit 7 sets on a parallel port access, software clears.
// - flag one bit 6 sets on a finished conversion, software clears.
// - flag one bit 5 reads 1 while receiver one holds data.
// - flag one bit 4 reads 1 while transmitter one buffer is empty.
// - flag one bit 3 sets when the sync serial port is done.
// - flag one bit 2 sets on a timer one gate event.
// - flag one bit 1 sets when timer two count meets its period.
// - flag one bit 0 sets on a timer one overflow.
// - flag three bit 7 sets on a timer five gate event.
// - unimplemented bits read zero and ignore writes.
`timescale 1ns/1ps
module peripheral_irq_flag_bank
  import flag_bank_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [ADDR_W-1:0]  wb_adr_i,
  input  wire logic [SEL_W-1:0]   wb_sel_i,
  input  wire logic [DATA_W-1:0]  wb_dat_i,
  output logic      [DATA_W-1:0]  wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               psp_access_i,
  input  wire logic               conversion_done_i,
  input  wire logic               sync_serial_done_i,
  input  wire logic               timer_one_gate_i,
  input  wire logic               timer_one_overflow_i,
  input  wire logic [7:0]         timer_two_count_i,
  input  wire logic [7:0]         timer_two_period_i,
  input  wire logic               timer_five_gate_i,
  input  wire logic               rx_one_full_i,
  input  wire logic               tx_one_empty_i,
  input  wire logic               rx_two_full_i,
  input  wire logic [OTHER_W-1:0] other_event_i,
  output logic      [7:0]         flags_one_o,
  output logic      [7:0]         flags_three_o,
  output logic                    irq_o
);

  // ************************************************************
  // reset
  // ************************************************************
  logic rst_n;

  reset_sync u_reset_sync (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .rst_n_o  (rst_n)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] adr);
    case (adr)
      ADDR_FLAGS_ONE:   reg_index = IDX_ONE;
      ADDR_FLAGS_TWO:   reg_index = IDX_TWO;
      ADDR_FLAGS_THREE: reg_index = IDX_THREE;
      ADDR_FLAGS_FOUR:  reg_index = IDX_FOUR;
      ADDR_FLAGS_FIVE:  reg_index = IDX_FIVE;
      ADDR_FLAGS_SIX:   reg_index = IDX_SIX;
      default:          reg_index = IDX_NONE;
    endcase
  endfunction

  function automatic logic [IRQ_W-1:0] lane_mask(input logic [SEL_W-1:0] sel);
    lane_mask = {{4{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // ************************************************************
  // bus slave
  // ************************************************************
  bus_state_t state;
  logic       req;
  logic       wr;
  logic [2:0] idx;
  logic       flag_hit;

  assign req      = wb_cyc_i && wb_stb_i && (state == BUS_IDLE);
  assign wr       = wb_cyc_i && wb_stb_i && wb_we_i && (state == BUS_ACK);
  assign idx      = reg_index(wb_adr_i);
  assign flag_hit = (idx != IDX_NONE);

  // one wait state; a write commits on the edge the master sees ack
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state    <= BUS_IDLE;
      wb_ack_o <= 1'b0;
    end else begin
      case (state)
        BUS_IDLE: begin
          wb_ack_o <= req;
          if (req) begin
            state <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          wb_ack_o <= 1'b0;
          state    <= BUS_IDLE;
        end
        default: begin
          wb_ack_o <= 1'b0;
          state    <= BUS_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // event sources
  // ************************************************************
  logic              t2_equal;
  logic              t2_equal_q;
  logic              t2_match;
  logic [2:0]        level;
  logic [2:0]        level_q;
  logic [FLAG_W-1:0] flag_set;

  assign t2_equal = (timer_two_count_i == timer_two_period_i);
  // equality can last many cycles; only its start is an event
  assign t2_match = t2_equal && !t2_equal_q;
  assign level    = {rx_two_full_i, tx_one_empty_i, rx_one_full_i};

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      t2_equal_q <= 1'b0;
      level_q    <= 3'h0;
    end else begin
      t2_equal_q <= t2_equal;
      level_q    <= level;
    end
  end

  always_comb begin
    flag_set           = '0;
    flag_set[BIT_PSP]  = psp_access_i;
    flag_set[BIT_CONV] = conversion_done_i;
    flag_set[BIT_SSP]  = sync_serial_done_i;
    flag_set[BIT_T1G]  = timer_one_gate_i;
    flag_set[BIT_T2M]  = t2_match;
    flag_set[BIT_T1OV] = timer_one_overflow_i;
    flag_set[BIT_T5G]  = timer_five_gate_i;
    flag_set[FLAG_W-1:16] = other_event_i;
  end

  // ************************************************************
  // flag registers
  // ************************************************************
  logic [FLAG_W-1:0] flags;
  logic [FLAG_W-1:0] flag_wr_en;
  logic [FLAG_W-1:0] flag_wr_data;

  // writes reach only the low byte lane; the bank mask keeps
  // read-only and unimplemented bits out
  assign flag_wr_en = (wr && flag_hit && wb_sel_i[0])
    ? (FLAG_W'(8'hff) << (BYTE_W * idx)) : '0;
  assign flag_wr_data = {NUM_FLAG_REGS{wb_dat_i[7:0]}};

  // set is independent of mask and enables
  sticky_bank #(
    .W    (FLAG_W),
    .W1C  (1'b0),
    .IMPL (STICKY_MASK),
    .RST  (FLAGS_RESET)
  ) u_flags (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n),
    .set_i     (flag_set),
    .wr_en_i   (flag_wr_en),
    .wr_data_i (flag_wr_data),
    .flags_o   (flags)
  );

  // read-only buffer flags follow the serial units, which drop
  // them when their buffer is accessed
  logic [FLAG_W-1:0] flag_view;

  always_comb begin
    flag_view          = flags;
    flag_view[BIT_RX1] = level_q[0];
    flag_view[BIT_TX1] = level_q[1];
    flag_view[BIT_RX2] = level_q[2];
  end

  assign flags_one_o   = flag_view[7:0];
  assign flags_three_o = flag_view[15:8];

  // ************************************************************
  // interrupt status and mask
  // ************************************************************
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_wr_en;
  logic             mask_wr;

  // level bits follow the view; an edge detector would fire after reset
  always_comb begin
    irq_set              = {4'h0, flag_set[15:0]};
    irq_set[BIT_RX1]     = level_q[0];
    irq_set[BIT_TX1]     = level_q[1];
    irq_set[BIT_RX2]     = level_q[2];
    irq_set[IRQ_OTHER_LO]   = |flag_set[23:16];
    irq_set[IRQ_OTHER_LO+1] = |flag_set[31:24];
    irq_set[IRQ_OTHER_LO+2] = |flag_set[39:32];
    irq_set[IRQ_OTHER_LO+3] = |flag_set[47:40];
  end

  assign irq_wr_en = (wr && wb_adr_i == ADDR_IRQ_STATUS)
    ? lane_mask(wb_sel_i) : '0;
  assign mask_wr   = wr && (wb_adr_i == ADDR_IRQ_MASK);

  sticky_bank #(
    .W    (IRQ_W),
    .W1C  (1'b1),
    .IMPL (IRQ_ALL),
    .RST  (IRQ_RESET)
  ) u_irq_status (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n),
    .set_i     (irq_set),
    .wr_en_i   (irq_wr_en),
    .wr_data_i (wb_dat_i[IRQ_W-1:0]),
    .flags_o   (irq_status)
  );

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= IRQ_RESET;
    end else if (mask_wr) begin
      irq_mask <= (irq_mask & ~lane_mask(wb_sel_i))
        | (wb_dat_i[IRQ_W-1:0] & lane_mask(wb_sel_i));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status & irq_mask);
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  logic [FLAG_W-1:0] flag_shift;

  assign flag_shift = flag_view >> (BYTE_W * idx);

  // unmapped addresses read zero and still get an ack
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= '0;
    end else if (req && !wb_we_i) begin
      if (flag_hit) begin
        wb_dat_o <= {24'h000000, flag_shift[7:0]};
      end else if (wb_adr_i == ADDR_IRQ_STATUS) begin
        wb_dat_o <= {12'h000, irq_status};
      end else if (wb_adr_i == ADDR_IRQ_MASK) begin
        wb_dat_o <= {12'h000, irq_mask};
      end else begin
        wb_dat_o <= '0;
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  logic clr_one;
  assign clr_one = wr && idx == IDX_ONE && wb_sel_i[0];
  a_event_free: assert property (
    psp_access_i |=> irq_status[BIT_PSP] && flags_one_o[BIT_PSP])
    else $error("event flag ignored");
  a_psp_set: assert property (
    psp_access_i |=> flags_one_o[7])
    else $error("parallel port flag not set");
  a_psp_clear: assert property (
    clr_one && !wb_dat_i[7] && !psp_access_i |=> !flags_one_o[7])
    else $error("parallel port flag not cleared");
  a_conv_set: assert property (
    conversion_done_i |=> flags_one_o[6])
    else $error("conversion flag not set");
  a_rx_one: assert property (
    ##1 flags_one_o[5] == $past(rx_one_full_i))
    else $error("receiver one flag wrong");
  a_tx_one: assert property (
    ##1 flags_one_o[4] == $past(tx_one_empty_i))
    else $error("transmitter one flag wrong");
  a_ssp_set: assert property (
    sync_serial_done_i |=> flags_one_o[3])
    else $error("serial port flag not set");
  a_gate_one: assert property (
    timer_one_gate_i |=> flags_one_o[2])
    else $error("timer one gate flag not set");
  a_match_set: assert property (
    timer_two_count_i == timer_two_period_i && !t2_equal_q
      |=> flags_one_o[1])
    else $error("timer two match flag not set");
  a_ovf_set: assert property (
    timer_one_overflow_i |=> flags_one_o[0])
    else $error("timer one overflow flag not set");
  a_gate_five: assert property (
    timer_five_gate_i |=> flags_three_o[7])
    else $error("timer five gate flag not set");
  a_unimpl_zero: assert property (
    flags_three_o[6] == 1'b0 && flags_three_o[4:0] == 5'h00)
    else $error("unimplemented bit reads one");
  a_rx_two: assert property (
    ##1 flags_three_o[5] == $past(rx_two_full_i))
    else $error("receiver two flag wrong");
  a_set_wins: assert property (
    clr_one && !wb_dat_i[6] && conversion_done_i |=> flags_one_o[6])
    else $error("event lost on clear");
  a_ack_pulse: assert property (
    req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle");
  a_irq_level: assert property (
    |(irq_status & irq_mask) |=> irq_o)
    else $error("interrupt not raised");

  c_write: cover property (clr_one);
  c_read: cover property (req && !wb_we_i && flag_hit);
  c_irq: cover property ($rose(irq_o));
  c_collide: cover property (clr_one && conversion_done_i);
endmodule

// ==== hdl/flag_bank_pkg.sv ====
package flag_bank_pkg;

  // ************************************************************
  // bus geometry
  // ************************************************************
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int SEL_W  = 4;
  localparam int BYTE_W = 8;

  // ************************************************************
  // register map, byte addresses
  // ************************************************************
  localparam logic [7:0] ADDR_FLAGS_ONE   = 8'h00;
  localparam logic [7:0] ADDR_FLAGS_TWO   = 8'h04;
  localparam logic [7:0] ADDR_FLAGS_THREE = 8'h08;
  localparam logic [7:0] ADDR_FLAGS_FOUR  = 8'h0c;
  localparam logic [7:0] ADDR_FLAGS_FIVE  = 8'h10;
  localparam logic [7:0] ADDR_FLAGS_SIX   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK    = 8'h1c;

  // ************************************************************
  // flag bank layout: byte 0 one, 1 three, 2 two, 3 four,
  // 4 five, 5 six
  // ************************************************************
  localparam int          NUM_FLAG_REGS = 6;
  localparam int          FLAG_W        = 48;
  localparam int          OTHER_W       = 32;
  localparam logic [2:0]  IDX_ONE       = 3'h0;
  localparam logic [2:0]  IDX_THREE     = 3'h1;
  localparam logic [2:0]  IDX_TWO       = 3'h2;
  localparam logic [2:0]  IDX_FOUR      = 3'h3;
  localparam logic [2:0]  IDX_FIVE      = 3'h4;
  localparam logic [2:0]  IDX_SIX       = 3'h5;
  localparam logic [2:0]  IDX_NONE      = 3'h7;
  localparam logic [47:0] STICKY_MASK   = 48'hffff_ffff_80cf;
  localparam logic [47:0] FLAGS_RESET   = 48'h0000_0000_0000;

  localparam int BIT_PSP  = 7;
  localparam int BIT_CONV = 6;
  localparam int BIT_RX1  = 5;
  localparam int BIT_TX1  = 4;
  localparam int BIT_SSP  = 3;
  localparam int BIT_T1G  = 2;
  localparam int BIT_T2M  = 1;
  localparam int BIT_T1OV = 0;
  localparam int BIT_T5G  = 15;
  localparam int BIT_RX2  = 13;

  // ************************************************************
  // interrupt status: [15:0] as bank bytes 0..1, [16+k] any
  // event of registers two, four, five, six
  // ************************************************************
  localparam int          IRQ_W        = 20;
  localparam int          IRQ_OTHER_LO = 16;
  localparam logic [19:0] IRQ_RESET    = 20'h00000;
  localparam logic [19:0] IRQ_ALL      = 20'hfffff;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;

endpackage

// ==== hdl/reset_sync.sv ====
`timescale 1ns/1ps
module reset_sync (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  output logic      rst_n_o
);

  logic meta_n;

  // release is synchronous, assertion stays asynchronous
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_n  <= 1'b0;
      rst_n_o <= 1'b0;
    end else begin
      meta_n  <= 1'b1;
      rst_n_o <= meta_n;
    end
  end

endmodule

// ==== hdl/sticky_bank.sv ====
`timescale 1ns/1ps
module sticky_bank #(
  parameter int          W      = 8,
  parameter bit          W1C    = 1'b0,
  parameter logic [W-1:0] IMPL   = '1,
  parameter logic [W-1:0] RST    = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] wr_en_i,
  input  wire logic [W-1:0] wr_data_i,
  output logic      [W-1:0] flags_o
);

  logic [W-1:0] kept;
  logic [W-1:0] next_flags;

  always_comb begin
    if (W1C) begin
      kept = flags_o & ~(wr_en_i & wr_data_i);
    end else begin
      kept = (flags_o & ~wr_en_i) | (wr_en_i & wr_data_i);
    end
    // a set in the same cycle as a clear wins
    next_flags = (kept | set_i) & IMPL;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_o <= RST;
    end else begin
      flags_o <= next_flags;
    end
  end

endmodule

// ==== verif/periph_event_model.sv ====
`timescale 1ns/1ps
module periph_event_model (
  input  wire logic        clk_i,
  output logic             psp_o,
  output logic             conv_o,
  output logic             ssp_o,
  output logic             t1g_o,
  output logic             t1ov_o,
  output logic             t5g_o,
  output logic             rx1_o,
  output logic             tx1_o,
  output logic             rx2_o,
  output logic       [7:0] count_o,
  output logic       [7:0] period_o,
  output logic      [31:0] other_o
);
  // ************************************************************
  // peripheral side: events as one-cycle pulses, buffers as levels
  // ************************************************************
  initial begin
    {psp_o, conv_o, ssp_o, t1g_o, t1ov_o, t5g_o} = 6'h00;
    {rx1_o, tx1_o, rx2_o} = 3'h0;
    count_o  = 8'h00;
    period_o = 8'h33;
    other_o  = 32'h0000_0000;
  end

  task automatic drive(input int s, input logic v);
    case (s)
      0: psp_o <= v;
      1: conv_o <= v;
      2: ssp_o <= v;
      3: t1g_o <= v;
      4: t1ov_o <= v;
      5: t5g_o <= v;
      // count meets period for a single cycle only
      10: count_o <= v ? 8'h33 : 8'h00;
      default: other_o[8*(s-6) +: 8] <= v ? 8'ha5 : 8'h00;
    endcase
  endtask

  task automatic fire(input int s);
    @(posedge clk_i);
    drive(s, 1'b1);
    @(posedge clk_i);
    drive(s, 1'b0);
  endtask

  // buffer levels rise and drop only when the test calls this task, on the next clock edge
  task automatic level(input int s, input logic v);
    @(posedge clk_i);
    case (s)
      0: rx1_o <= v;
      1: tx1_o <= v;
      default: rx2_o <= v;
    endcase
  endtask
endmodule

// ==== verif/tb_peripheral_irq_flag_bank.sv ====
`timescale 1ns/1ps
module tb_peripheral_irq_flag_bank;
  import flag_bank_pkg::*;
  typedef struct {
    int          ev;
    logic [7:0]  adr;
    logic [31:0] exp;
  } row_t;

  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        cyc, stb, we, ack, irq;
  logic [7:0]  adr, f1, f3, count, period, lvl_adr;
  logic [3:0]  sel;
  logic [3:0]  lanes = 4'hf;
  logic [31:0] wdat, rdat, other, rd, exp_pins, lvl_exp;
  logic        psp, conv, ssp, t1g, t1ov, t5g, rx1, tx1, rx2;
  int          failures = 0;
  int          samples_checked = 0;
  row_t        rows [11] = '{'{0, 8'h00, 32'h80}, '{1, 8'h00, 32'h40},
    '{2, 8'h00, 32'h08}, '{3, 8'h00, 32'h04}, '{10, 8'h00, 32'h02},
    '{4, 8'h00, 32'h01}, '{5, 8'h08, 32'h80}, '{6, 8'h04, 32'ha5},
    '{7, 8'h0c, 32'ha5}, '{8, 8'h10, 32'ha5}, '{9, 8'h14, 32'ha5}};

  always #5 clk_i = ~clk_i;

  peripheral_irq_flag_bank u_peripheral_irq_flag_bank (
    .clk_i(clk_i), .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .psp_access_i(psp),
    .conversion_done_i(conv), .sync_serial_done_i(ssp),
    .timer_one_gate_i(t1g), .timer_one_overflow_i(t1ov),
    .timer_two_count_i(count), .timer_two_period_i(period),
    .timer_five_gate_i(t5g), .rx_one_full_i(rx1), .tx_one_empty_i(tx1),
    .rx_two_full_i(rx2), .other_event_i(other), .flags_one_o(f1),
    .flags_three_o(f3), .irq_o(irq));

  periph_event_model u_model (
    .clk_i(clk_i), .psp_o(psp), .conv_o(conv), .ssp_o(ssp), .t1g_o(t1g),
    .t1ov_o(t1ov), .t5g_o(t5g), .rx1_o(rx1), .tx1_o(tx1), .rx2_o(rx2),
    .count_o(count), .period_o(period), .other_o(other));

  // ************************************************************
  // shared checking and bus tasks
  // ************************************************************
  task automatic report_and_stop();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // the master never assumes a latency, only the bound cuts a hang
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge clk_i);
    {cyc, stb, we, adr, sel, wdat} <= {1'b1, 1'b1, w, a, lanes, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      failures++;
      report_and_stop();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  initial begin
    {cyc, stb, we, adr, sel, wdat} = '0;
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // ************************************************************
    // one event per row, mask left at zero throughout
    // ************************************************************
    foreach (rows[i]) begin
      u_model.fire(rows[i].ev);
      rd_chk(rows[i].adr, rows[i].exp);
      exp_pins = rows[i].adr == 8'h00 ? rows[i].exp :
                 rows[i].adr == 8'h08 ? rows[i].exp << 8 : 32'h0;
      check({16'h0, f3, f1}, exp_pins);
      check({31'h0, irq}, 32'h0);
      xfer(1'b1, rows[i].adr, 32'h0);
      rd_chk(rows[i].adr, 32'h0);
    end
    // buffer levels are read-only and follow the serial units
    for (int i = 0; i < 3; i++) begin
      lvl_adr = i == 2 ? 8'h08 : 8'h00;
      lvl_exp = i == 1 ? 32'h10 : 32'h20;
      u_model.level(i, 1'b1);
      rd_chk(lvl_adr, lvl_exp);
      xfer(1'b1, lvl_adr, 32'h0);
      rd_chk(lvl_adr, lvl_exp);
      u_model.level(i, 1'b0);
      rd_chk(lvl_adr, 32'h0);
    end
    xfer(1'b1, 8'h08, 32'hff);
    rd_chk(8'h08, 32'h80);
    // without byte lane zero a flag write changes nothing
    lanes = 4'he;
    xfer(1'b1, 8'h08, 32'h0);
    lanes = 4'hf;
    rd_chk(8'h08, 32'h80);
    xfer(1'b1, 8'h08, 32'h0);
    // the event lands on the edge that commits the clearing write
    fork
      xfer(1'b1, 8'h00, 32'h0);
      begin
        @(posedge clk_i);
        u_model.fire(1);
      end
    join
    rd_chk(8'h00, 32'h40);
    xfer(1'b1, 8'h40, 32'hff);
    rd_chk(8'h40, 32'h0);
    // ************************************************************
    // interrupt: status cleared before the mask opens
    // ************************************************************
    xfer(1'b1, 8'h00, 32'h0);
    xfer(1'b1, ADDR_IRQ_STATUS, {12'h0, IRQ_ALL});
    rd_chk(ADDR_IRQ_STATUS, 32'h0);
    xfer(1'b1, ADDR_IRQ_MASK, 32'h80);
    check({31'h0, irq}, 32'h0);
    u_model.fire(0);
    repeat (3) @(posedge clk_i);
    check({31'h0, irq}, 32'h1);
    rd_chk(ADDR_IRQ_STATUS, 32'h80);
    xfer(1'b1, ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq}, 32'h0);
    xfer(1'b1, ADDR_IRQ_MASK, 32'h80);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq}, 32'h1);
    xfer(1'b1, ADDR_IRQ_STATUS, 32'h80);
    repeat (2) @(posedge clk_i);
    check({31'h0, irq}, 32'h0);
    rd_chk(8'h00, 32'h80);
    // ************************************************************
    // reset in mid-run with a flag and the mask set
    // ************************************************************
    u_model.fire(1);
    @(posedge clk_i);
    check({24'h0, f1}, 32'hc0);
    resetn_i <= 1'b0;
    @(posedge clk_i);
    #1;
    check({15'h0, irq, f3, f1}, 32'h0);
    @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (int a = 0; a < 32; a += 4) begin
      rd_chk(8'(a), 32'h0);
    end
    report_and_stop();
  end
endmodule
